// >>> pkg/mbexr_pkg.sv
// constants and types shared by the exception responder
package mbexr_pkg;

   // ----------------------------------------------------------------
   // exception codes
   // ----------------------------------------------------------------
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
   localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
   localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
   localparam logic [7:0] EXC_DEVICE_FAIL = 8'h04;
   localparam logic [7:0] EXC_ACKNOWLEDGE = 8'h05;
   localparam logic [7:0] EXC_DEVICE_BUSY = 8'h06;
   localparam logic [7:0] EXC_MEM_PARITY = 8'h08;
   localparam logic [7:0] EXC_GW_PATH = 8'h0a;
   localparam logic [7:0] EXC_GW_TARGET = 8'h0b;

   // ----------------------------------------------------------------
   // function codes and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] EXC_FUNC_FLAG = 8'h80;
   localparam logic [7:0] FN_READ_COILS = 8'h01;
   localparam logic [7:0] FN_READ_INPUTS = 8'h02;
   localparam logic [7:0] FN_READ_HOLDING = 8'h03;
   localparam logic [7:0] FN_READ_INPUT_REGS = 8'h04;
   localparam logic [7:0] FN_WRITE_COIL = 8'h05;
   localparam logic [7:0] FN_WRITE_REG = 8'h06;
   localparam logic [7:0] FN_WRITE_COILS = 8'h0f;
   localparam logic [7:0] FN_WRITE_REGS = 8'h10;
   localparam logic [7:0] FN_READ_FILE = 8'h14;
   localparam logic [7:0] FN_WRITE_FILE = 8'h15;
   localparam logic [7:0] REF_TYPE_FILE = 8'h06;
   localparam logic [16:0] SINGLE_QTY = 17'h00001;

   // ----------------------------------------------------------------
   // sizes and reset values
   // ----------------------------------------------------------------
   localparam int NUM_REGS_DEFAULT = 100;
   localparam int NUM_REGS_MAX = 65536;
   localparam logic [7:0] RESP_FUNC_RESET = 8'h00;

   typedef enum logic [1:0]
   {
      MBEXR_IDLE = 2'b01,
      MBEXR_LONG_OP = 2'b10
   } mbexr_state_t;

endpackage

// >>> rtl/mbexr_responder.sv
// exception decision logic of a serial protocol slave
// Behaviour
// - unsupported function answers code 01
// - unconfigured slave answers data requests 01
// - start plus length past range answers 02
// - range check includes last register
// - inconsistent request structure answers 03
// - register values never checked for 03
// - internal execution failure answers 04
// - accepted long programming command answers 05
// - programming request during long operation answers 06
// - file read or write parity failure answers 08
// - gateway without internal path answers 0a
// - gateway target silent answers 0b
// - exception echoes function with top bit
// - exception code replaces requested data
// - communication error gives no response
module mbexr_responder #(
   parameter int NUM_REGS = mbexr_pkg::NUM_REGS_DEFAULT
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic q_valid,
   input wire logic [7:0] q_func,
   input wire logic [15:0] q_start,
   input wire logic [15:0] q_qty,
   input wire logic [7:0] q_ref_type,
   input wire logic q_comm_err,
   input wire logic q_struct_err,
   input wire logic q_prog,
   input wire logic q_prog_long,
   input wire logic q_parity_err,
   input wire logic q_exec_fault,
   input wire logic q_path_fail,
   input wire logic q_target_noresp,
   input wire logic cfg_done,
   input wire logic gw_mode,
   input wire logic prog_done,
   output logic resp_valid,
   output logic resp_drop,
   output logic resp_exc,
   output logic [7:0] resp_func,
   output logic [7:0] resp_code,
   output logic prog_busy
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (NUM_REGS < 1 || NUM_REGS > mbexr_pkg::NUM_REGS_MAX)
   begin : g_bad_size
      $error("NUM_REGS out of range");
   end

   localparam logic [16:0] REG_LIMIT = 17'(NUM_REGS);

   // ----------------------------------------------------------------
   // function decoding
   // ----------------------------------------------------------------
   function automatic logic is_supported(input logic [7:0] fn);
      case (fn)
         mbexr_pkg::FN_READ_COILS,
         mbexr_pkg::FN_READ_INPUTS,
         mbexr_pkg::FN_READ_HOLDING,
         mbexr_pkg::FN_READ_INPUT_REGS,
         mbexr_pkg::FN_WRITE_COIL,
         mbexr_pkg::FN_WRITE_REG,
         mbexr_pkg::FN_WRITE_COILS,
         mbexr_pkg::FN_WRITE_REGS,
         mbexr_pkg::FN_READ_FILE,
         mbexr_pkg::FN_WRITE_FILE: is_supported = 1'b1;
         default: is_supported = 1'b0;
      endcase
   endfunction

   function automatic logic is_file_fn(input logic [7:0] fn);
      is_file_fn = (fn == mbexr_pkg::FN_READ_FILE) || (fn == mbexr_pkg::FN_WRITE_FILE);
   endfunction

   // data functions are the supported ones except the record-file pair
   function automatic logic is_data_fn(input logic [7:0] fn);
      is_data_fn = is_supported(fn) && !is_file_fn(fn);
   endfunction

   function automatic logic is_single_fn(input logic [7:0] fn);
      is_single_fn = (fn == mbexr_pkg::FN_WRITE_COIL) || (fn == mbexr_pkg::FN_WRITE_REG);
   endfunction

   // ----------------------------------------------------------------
   // classification
   // ----------------------------------------------------------------
   mbexr_pkg::mbexr_state_t state_reg;
   mbexr_pkg::mbexr_state_t state_next;
   logic [16:0] eff_qty;
   logic [16:0] end_addr;
   logic addr_over;
   logic fn_ok;
   logic cfg_ok;
   logic path_ok;
   logic pre_ok;
   logic accepted;
   logic [7:0] code;

   always_comb
   begin
      eff_qty = is_single_fn(q_func) ? mbexr_pkg::SINGLE_QTY : {1'b0, q_qty};
      end_addr = {1'b0, q_start} + eff_qty;
      addr_over = end_addr > REG_LIMIT;
      fn_ok = is_supported(q_func);
      cfg_ok = !is_data_fn(q_func) || cfg_done;
      path_ok = !(gw_mode && q_path_fail);
      pre_ok = fn_ok && cfg_ok && path_ok && !q_struct_err && !(is_data_fn(q_func) && addr_over);
      accepted = q_valid && !q_comm_err;
      // priority order; written data values never enter this decision
      code = mbexr_pkg::EXC_NONE;
      if (!fn_ok)
      begin
         code = mbexr_pkg::EXC_ILLEGAL_FUNC;
      end
      else if (!cfg_ok)
      begin
         code = mbexr_pkg::EXC_ILLEGAL_FUNC;
      end
      else if (!path_ok)
      begin
         code = mbexr_pkg::EXC_GW_PATH;
      end
      else if (q_struct_err)
      begin
         code = mbexr_pkg::EXC_ILLEGAL_VALUE;
      end
      else if (is_data_fn(q_func) && addr_over)
      begin
         code = mbexr_pkg::EXC_ILLEGAL_ADDR;
      end
      else if (q_prog && state_reg == mbexr_pkg::MBEXR_LONG_OP)
      begin
         code = mbexr_pkg::EXC_DEVICE_BUSY;
      end
      else if (is_file_fn(q_func) && q_ref_type == mbexr_pkg::REF_TYPE_FILE && q_parity_err)
      begin
         code = mbexr_pkg::EXC_MEM_PARITY;
      end
      else if (q_exec_fault)
      begin
         code = mbexr_pkg::EXC_DEVICE_FAIL;
      end
      else if (gw_mode && q_target_noresp)
      begin
         code = mbexr_pkg::EXC_GW_TARGET;
      end
      else if (q_prog && q_prog_long)
      begin
         code = mbexr_pkg::EXC_ACKNOWLEDGE;
      end
   end

   // ----------------------------------------------------------------
   // long programming operation tracking
   // ----------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         mbexr_pkg::MBEXR_IDLE:
         begin
            if (accepted && code == mbexr_pkg::EXC_ACKNOWLEDGE)
            begin
               state_next = mbexr_pkg::MBEXR_LONG_OP;
            end
         end
         mbexr_pkg::MBEXR_LONG_OP:
         begin
            if (prog_done)
            begin
               state_next = mbexr_pkg::MBEXR_IDLE;
            end
         end
         default: state_next = mbexr_pkg::MBEXR_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= mbexr_pkg::MBEXR_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // response registers
   // ----------------------------------------------------------------
   logic resp_valid_reg, resp_valid_next;
   logic resp_drop_reg, resp_drop_next;
   logic resp_exc_reg, resp_exc_next;
   logic [7:0] resp_func_reg, resp_func_next;
   logic [7:0] resp_code_reg, resp_code_next;
   logic prog_busy_reg, prog_busy_next;

   always_comb
   begin
      resp_valid_next = accepted;
      resp_drop_next = q_valid && q_comm_err;
      resp_exc_next = resp_exc_reg;
      resp_func_next = resp_func_reg;
      resp_code_next = resp_code_reg;
      if (accepted)
      begin
         resp_exc_next = code != mbexr_pkg::EXC_NONE;
         resp_code_next = code;
         resp_func_next = (code != mbexr_pkg::EXC_NONE) ?
                          (q_func | mbexr_pkg::EXC_FUNC_FLAG) : q_func;
      end
      prog_busy_next = state_next == mbexr_pkg::MBEXR_LONG_OP;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         resp_valid_reg <= 1'b0;
         resp_drop_reg <= 1'b0;
         resp_exc_reg <= 1'b0;
         resp_func_reg <= mbexr_pkg::RESP_FUNC_RESET;
         resp_code_reg <= mbexr_pkg::EXC_NONE;
         prog_busy_reg <= 1'b0;
      end
      else
      begin
         resp_valid_reg <= resp_valid_next;
         resp_drop_reg <= resp_drop_next;
         resp_exc_reg <= resp_exc_next;
         resp_func_reg <= resp_func_next;
         resp_code_reg <= resp_code_next;
         prog_busy_reg <= prog_busy_next;
      end
   end

   assign resp_valid = resp_valid_reg;
   assign resp_drop = resp_drop_reg;
   assign resp_exc = resp_exc_reg;
   assign resp_func = resp_func_reg;
   assign resp_code = resp_code_reg;
   assign prog_busy = prog_busy_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_illegal_func;
      @(posedge core_clk) disable iff (rst)
      accepted && !is_supported(q_func) |=>
         resp_valid && resp_code == mbexr_pkg::EXC_ILLEGAL_FUNC &&
         resp_func == ($past(q_func) | mbexr_pkg::EXC_FUNC_FLAG);
   endproperty
   a_illegal_func: assert property (p_illegal_func) else $error("no code 01");

   property p_unconfigured;
      @(posedge core_clk) disable iff (rst)
      accepted && is_data_fn(q_func) && !cfg_done |=> resp_code == mbexr_pkg::EXC_ILLEGAL_FUNC;
   endproperty
   a_unconfigured: assert property (p_unconfigured) else $error("unconfigured not 01");

   property p_range;
      @(posedge core_clk) disable iff (rst)
      accepted && fn_ok && cfg_ok && path_ok && !q_struct_err && is_data_fn(q_func) &&
      ({1'b0, q_start} + {1'b0, q_qty} > REG_LIMIT) && !is_single_fn(q_func) |=>
         resp_exc && resp_code == mbexr_pkg::EXC_ILLEGAL_ADDR;
   endproperty
   a_range: assert property (p_range) else $error("overrun not 02");

   property p_inclusive;
      @(posedge core_clk) disable iff (rst)
      accepted && is_data_fn(q_func) && !is_single_fn(q_func) &&
      ({1'b0, q_start} + {1'b0, q_qty} == REG_LIMIT) |=>
         resp_code != mbexr_pkg::EXC_ILLEGAL_ADDR;
   endproperty
   a_inclusive: assert property (p_inclusive) else $error("last register refused");

   property p_structure;
      @(posedge core_clk) disable iff (rst)
      accepted && fn_ok && cfg_ok && path_ok && q_struct_err |=>
         resp_code == mbexr_pkg::EXC_ILLEGAL_VALUE;
   endproperty
   a_structure: assert property (p_structure) else $error("bad structure not 03");

   property p_acknowledge;
      @(posedge core_clk) disable iff (rst)
      accepted && pre_ok && q_prog && q_prog_long && !prog_busy && !q_exec_fault &&
      !(gw_mode && q_target_noresp) && !is_file_fn(q_func) |=>
         resp_code == mbexr_pkg::EXC_ACKNOWLEDGE ##1 prog_busy || $past(prog_done);
   endproperty
   a_acknowledge: assert property (p_acknowledge) else $error("long command not 05");

   property p_busy;
      @(posedge core_clk) disable iff (rst)
      accepted && pre_ok && q_prog && state_reg == mbexr_pkg::MBEXR_LONG_OP |=>
         resp_exc && resp_code == mbexr_pkg::EXC_DEVICE_BUSY;
   endproperty
   a_busy: assert property (p_busy) else $error("busy not 06");

   property p_drop;
      @(posedge core_clk) disable iff (rst)
      q_valid && q_comm_err |=> resp_drop && !resp_valid && $stable(resp_code);
   endproperty
   a_drop: assert property (p_drop) else $error("errored query answered");

   property p_flag;
      @(posedge core_clk) disable iff (rst)
      resp_valid |-> (resp_exc == resp_func[7]) && (resp_exc == (resp_code != 8'h00));
   endproperty
   a_flag: assert property (p_flag) else $error("function flag mismatch");

   property p_clean;
      @(posedge core_clk) disable iff (rst)
      accepted && pre_ok && !q_prog && !q_parity_err && !q_exec_fault && !q_target_noresp |=>
         resp_valid && !resp_exc && resp_func == $past(q_func);
   endproperty
   a_clean: assert property (p_clean) else $error("clean query refused");

   property p_gateway;
      @(posedge core_clk) disable iff (rst)
      accepted && fn_ok && cfg_ok && gw_mode && q_path_fail |=>
         resp_code == mbexr_pkg::EXC_GW_PATH;
   endproperty
   a_gateway: assert property (p_gateway) else $error("path fail not 0a");

endmodule

// >>> testbench/mbexr_master_model.sv
// serial master model: issues queries, collects answers, retries
module mbexr_master_model #(
   parameter int RETRY_MAX = 3
)
(
   input wire logic core_clk,
   output logic q_valid,
   output logic [7:0] q_func,
   output logic [15:0] q_start,
   output logic [15:0] q_qty,
   output logic [7:0] q_ref_type,
   output logic [7:0] q_flags,
   input wire logic resp_valid,
   input wire logic resp_drop,
   input wire logic resp_exc,
   input wire logic [7:0] resp_func,
   input wire logic [7:0] resp_code
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      q_valid = 1'b0;
      q_func = 8'h00;
      q_start = 16'h0000;
      q_qty = 16'h0000;
      q_ref_type = 8'h00;
      q_flags = 8'h00;
   end

   // one query, answer read one cycle later; fields scrambled when idle
   task automatic ask(input logic [7:0] fn, input logic [15:0] st, input logic [15:0] qt,
                      input logic [7:0] rf, input logic [7:0] fl, output logic v,
                      output logic d, output logic e, output logic [7:0] f, output logic [7:0] c);
      @(posedge core_clk);
      q_valid <= 1'b1;
      q_func <= fn;
      q_start <= st;
      q_qty <= qt;
      q_ref_type <= rf;
      q_flags <= fl;
      @(posedge core_clk);
      q_valid <= 1'b0;
      q_func <= ~fn;
      q_start <= ~st;
      q_qty <= ~qt;
      q_ref_type <= ~rf;
      q_flags <= ~fl;
      @(negedge core_clk);
      v = resp_valid;
      d = resp_drop;
      e = resp_exc;
      f = resp_func;
      c = resp_code;
   endtask

   // resend while busy or parity answers come back, at most RETRY_MAX queries in all
   task automatic ask_retry(input logic [7:0] fn, input logic [15:0] st, input logic [15:0] qt,
                            input logic [7:0] rf, input logic [7:0] fl, output logic [7:0] first,
                            output logic [7:0] last, output int tries);
      logic v;
      logic d;
      logic e;
      logic [7:0] f;
      tries = 0;
      first = 8'h00;
      last = mbexr_pkg::EXC_DEVICE_BUSY;
      while ((last === mbexr_pkg::EXC_DEVICE_BUSY || last === mbexr_pkg::EXC_MEM_PARITY)
             && tries < RETRY_MAX)
      begin
         if (tries > 0)
            repeat (4) @(posedge core_clk);
         ask(fn, st, qt, rf, fl, v, d, e, f, last);
         if (tries == 0)
            first = last;
         tries++;
      end
   endtask
endmodule

// >>> testbench/modbus_exception_responder_tb.sv
// self-checking bench of the exception responder
module modbus_exception_responder_tb;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [7:0] fn;
      logic [15:0] st;
      logic [15:0] qt;
      logic [7:0] rf;
      logic [7:0] fl;
      logic cfg;
      logic gw;
      logic [7:0] code;
   } mbexr_row_t;

   // flags: comm struct prog long parity exec path noresp
   mbexr_row_t rows [19] = '{
      '{8'h03, 16'd96, 16'd4, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00},
      '{8'h03, 16'd96, 16'd5, 8'h00, 8'h00, 1'b1, 1'b0, 8'h02},
      '{8'h01, 16'd0, 16'd100, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00},
      '{8'h02, 16'd99, 16'd1, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00},
      '{8'h04, 16'd0, 16'd101, 8'h00, 8'h00, 1'b1, 1'b0, 8'h02},
      '{8'h05, 16'd99, 16'hffff, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00},
      '{8'h06, 16'd99, 16'h0000, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00},
      '{8'h0f, 16'd50, 16'd50, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00},
      '{8'h07, 16'd0, 16'd1, 8'h00, 8'h00, 1'b1, 1'b0, 8'h01},
      '{8'h7f, 16'd0, 16'd1, 8'h00, 8'h00, 1'b1, 1'b0, 8'h01},
      '{8'h03, 16'd0, 16'd1, 8'h00, 8'h00, 1'b0, 1'b0, 8'h01},
      '{8'h10, 16'd0, 16'd1, 8'h00, 8'h40, 1'b1, 1'b0, 8'h03},
      '{8'h14, 16'd0, 16'd1, 8'h06, 8'h08, 1'b1, 1'b0, 8'h08},
      '{8'h15, 16'd0, 16'd1, 8'h06, 8'h08, 1'b1, 1'b0, 8'h08},
      '{8'h14, 16'd0, 16'd1, 8'h00, 8'h08, 1'b1, 1'b0, 8'h00},
      '{8'h03, 16'd0, 16'd1, 8'h00, 8'h04, 1'b1, 1'b0, 8'h04},
      '{8'h03, 16'd0, 16'd1, 8'h00, 8'h02, 1'b1, 1'b1, 8'h0a},
      '{8'h03, 16'd0, 16'd1, 8'h00, 8'h01, 1'b1, 1'b1, 8'h0b},
      '{8'h03, 16'd0, 16'd1, 8'h00, 8'h01, 1'b1, 1'b0, 8'h00}
   };

   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic cfg_done = 1'b0;
   logic gw_mode = 1'b0;
   logic prog_done = 1'b0;
   logic q_valid;
   logic [7:0] q_func;
   logic [15:0] q_start;
   logic [15:0] q_qty;
   logic [7:0] q_ref_type;
   logic [7:0] q_flags;
   logic resp_valid;
   logic resp_drop;
   logic resp_exc;
   logic [7:0] resp_func;
   logic [7:0] resp_code;
   logic prog_busy;
   logic v;
   logic d;
   logic e;
   logic exc;
   logic [7:0] f;
   logic [7:0] c;
   logic [7:0] first;
   int tries;
   int errors = 0;
   int samples_checked = 0;

   always #2.5 core_clk = ~core_clk;

   mbexr_responder #(.NUM_REGS(100)) i_dut (.core_clk(core_clk), .rst(rst),
      .q_valid(q_valid), .q_func(q_func), .q_start(q_start), .q_qty(q_qty),
      .q_ref_type(q_ref_type), .q_comm_err(q_flags[7]), .q_struct_err(q_flags[6]),
      .q_prog(q_flags[5]), .q_prog_long(q_flags[4]), .q_parity_err(q_flags[3]),
      .q_exec_fault(q_flags[2]), .q_path_fail(q_flags[1]), .q_target_noresp(q_flags[0]),
      .cfg_done(cfg_done), .gw_mode(gw_mode), .prog_done(prog_done),
      .resp_valid(resp_valid), .resp_drop(resp_drop), .resp_exc(resp_exc),
      .resp_func(resp_func), .resp_code(resp_code), .prog_busy(prog_busy));

   mbexr_master_model i_master (.core_clk(core_clk), .q_valid(q_valid), .q_func(q_func),
      .q_start(q_start), .q_qty(q_qty), .q_ref_type(q_ref_type), .q_flags(q_flags),
      .resp_valid(resp_valid), .resp_drop(resp_drop), .resp_exc(resp_exc),
      .resp_func(resp_func), .resp_code(resp_code));

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      chk8({7'h00, got}, {7'h00, exp}, what);
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      repeat (50000) @(posedge core_clk);
      errors++;
      $display("[ERR] %0t run timed out", $time);
      finish_test();
   end

   initial
   begin
      repeat (16) @(posedge core_clk);
      chk1(|{resp_valid, resp_drop, resp_exc, resp_func, resp_code, prog_busy}, 1'b0, "reset");
      rst <= 1'b0;
      foreach (rows[i])
      begin
         @(posedge core_clk);
         cfg_done <= rows[i].cfg;
         gw_mode <= rows[i].gw;
         i_master.ask(rows[i].fn, rows[i].st, rows[i].qt, rows[i].rf, rows[i].fl, v, d, e, f, c);
         exc = (rows[i].code !== 8'h00);
         chk1(v, 1'b1, "valid");
         chk1(d, 1'b0, "drop");
         chk1(e, exc, "exc flag");
         chk8(f, exc ? (rows[i].fn | mbexr_pkg::EXC_FUNC_FLAG) : rows[i].fn, "func");
         chk8(c, rows[i].code, "code");
      end
      @(posedge core_clk);
      gw_mode <= 1'b0;
      i_master.ask(8'h03, 16'd96, 16'd5, 8'h00, 8'h00, v, d, e, f, c);
      i_master.ask(8'h03, 16'd0, 16'd1, 8'h00, 8'h80, v, d, e, f, c);
      chk1(v, 1'b0, "comm valid");
      chk1(d, 1'b1, "comm drop");
      chk8(f, 8'h83, "comm func held");
      chk8(c, 8'h02, "comm code held");
      i_master.ask(8'h10, 16'd0, 16'd1, 8'h00, 8'h30, v, d, e, f, c);
      chk8(c, mbexr_pkg::EXC_ACKNOWLEDGE, "ack code");
      chk1(prog_busy, 1'b1, "busy set");
      i_master.ask(8'h03, 16'd0, 16'd1, 8'h00, 8'h00, v, d, e, f, c);
      chk8(c, 8'h00, "poll code");
      fork
         i_master.ask_retry(8'h10, 16'd0, 16'd1, 8'h00, 8'h20, first, c, tries);
         begin
            repeat (3) @(posedge core_clk);
            prog_done <= 1'b1;
            @(posedge core_clk);
            prog_done <= 1'b0;
         end
      join
      chk8(first, mbexr_pkg::EXC_DEVICE_BUSY, "busy code");
      chk8(c, 8'h00, "retry code");
      chk1(prog_busy, 1'b0, "busy cleared");
      i_master.ask_retry(8'h14, 16'd0, 16'd1, 8'h06, 8'h08, first, c, tries);
      chk8(c, mbexr_pkg::EXC_MEM_PARITY, "parity retry");
      chk8(tries[7:0], 8'h03, "parity tries");
      i_master.ask(8'h10, 16'd0, 16'd1, 8'h00, 8'h30, v, d, e, f, c);
      @(posedge core_clk);
      rst <= 1'b1;
      @(negedge core_clk);
      chk1(|{resp_valid, resp_drop, resp_exc, resp_func, resp_code, prog_busy}, 1'b0, "mid reset");
      @(posedge core_clk);
      rst <= 1'b0;
      // reset must have ended the long operation: a short program command passes
      i_master.ask(8'h10, 16'd0, 16'd1, 8'h00, 8'h20, v, d, e, f, c);
      chk1(v, 1'b1, "post reset valid");
      chk8(c, 8'h00, "post reset code");
      chk1(prog_busy, 1'b0, "post reset busy");
      finish_test();
   end
endmodule
